// *** design/dma_router.sv ***
`timescale 1ns/10ps
module dma_router (
   input  wire logic core_clk,
   input  wire logic rst,
   mode_cfg_if.dst   cfg,
   input  wire logic host_dma_request,
   input  wire logic periph_dma_request,
   input  wire logic ack_level,
   output logic      host_dma_request_pin,
   output logic      host_dma_ack,
   output logic      periph_dma_ack
);

   typedef struct packed {
      logic req_pin;
      logic host_ack;
      logic periph_ack;
   } router_state_t;

   router_state_t s_q;
   router_state_t s_d;
   logic          req_src;
   logic          ack_act;

   // ****************************************************************
   // request select and polarity, acknowledge decode and steering
   // ****************************************************************
   always_comb begin
      s_d = s_q;
      req_src = cfg.dma_route ? periph_dma_request : host_dma_request;
      s_d.req_pin = cfg.request_polarity ? req_src : ~req_src;
      ack_act = cfg.ack_polarity ? ack_level : ~ack_level;
      s_d.periph_ack = cfg.dma_route & ack_act;
      s_d.host_ack = ~cfg.dma_route & ack_act;
   end

   // state register, request pin idles inactive for active-low reset polarity
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '{req_pin: 1'b1, host_ack: 1'b0, periph_ack: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign host_dma_request_pin = s_q.req_pin;
   assign host_dma_ack         = s_q.host_ack;
   assign periph_dma_ack       = s_q.periph_ack;

endmodule

// *** design/hardware_mode_control.sv ***
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
module hardware_mode_control
   import hw_mode_pkg::*;
(
   // clock and reset
   input  wire logic                                core_clk,
   input  wire logic                                rst,

   // apb slave
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [hw_mode_pkg::ADDR_W-1:0]      paddr,
   input  wire logic [hw_mode_pkg::DATA_W-1:0]      pwdata,
   output logic      [hw_mode_pkg::DATA_W-1:0]      prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   output logic                                     irq,

   // controller side: same-clock signals, no synchroniser
   input  wire logic                                host_event,
   input  wire logic                                periph_interrupt,
   input  wire logic                                host_dma_request,
   input  wire logic                                periph_dma_request,
   output logic                                     host_dma_ack,
   output logic                                     periph_dma_ack,
   output logic                                     usb_transceiver_reset,
   output logic                                     host_bus_32,
   output logic                                     periph_bus_32,
   output logic                                     otg_bus_32,
   output logic      [hw_mode_pkg::NUM_PORTS-1:0]   port_overcurrent,

   // pins: each asynchronous input passes two flops first
   input  wire logic                                port1_overcurrent_in,
   input  wire logic                                port2_overcurrent_in,
   input  wire logic                                port3_overcurrent_in,
   input  wire logic [hw_mode_pkg::NUM_PORTS-1:0]   analog_oc_cmp,
   input  wire logic                                host_dma_ack_pin,
   output logic                                     host_dma_request_pin,
   output logic                                     host_interrupt_pin
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      // software-visible registers
      logic [DATA_W-1:0]    mode;
      logic [NUM_EV-1:0]    status;
      logic [NUM_EV-1:0]    enable;
      // bus response held through the access cycle, and the level interrupt
      logic [DATA_W-1:0]    rdata;
      logic                 ready;
      logic                 slverr;
      logic                 irq;
      // pin synchronisers, first stage read only by the second
      logic [NUM_PORTS-1:0] oc_meta;
      logic [NUM_PORTS-1:0] oc_sync;
      logic [NUM_PORTS-1:0] cmp_meta;
      logic [NUM_PORTS-1:0] cmp_sync;
      logic                 ack_meta;
      logic                 ack_sync;
      // detected overcurrent, also the edge reference
      logic [NUM_PORTS-1:0] oc_flag;
   } top_state_t;

   top_state_t           s_q;
   top_state_t           s_d;

   // bus decode
   logic                 setup;
   logic                 access_done;
   logic                 hit_mode;
   logic                 hit_status;
   logic                 hit_enable;

   // events, clears and the shaper request
   logic [NUM_EV-1:0]    events;
   logic [NUM_EV-1:0]    w1c;
   logic [NUM_PORTS-1:0] oc_now;
   logic                 irq_request;

   // bundle shared by the shaper and the router
   mode_cfg_if cfg ();

   // ****************************************************************
   // configuration fan-out to the shaping and routing blocks
   // ****************************************************************
   assign cfg.ack_polarity      = s_q.mode[BIT_ACK_POL];
   assign cfg.request_polarity  = s_q.mode[BIT_REQ_POL];
   assign cfg.irq_polarity      = s_q.mode[BIT_IRQ_POL];
   assign cfg.irq_trigger_type  = s_q.mode[BIT_IRQ_TRIG];
   assign cfg.irq_master_enable = s_q.mode[BIT_IRQ_EN];
   // sharing needs both routing bits; either one alone
   // leaves the host controller on its own pins
   assign cfg.dma_route         = s_q.mode[BIT_PERIPH_DMA] & s_q.mode[BIT_SHARED_DMA];

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      s_d = s_q;

      // two-stage synchronisers for pin inputs; the pins are
      // asynchronous, so logic reads only the second stage
      s_d.oc_meta  = {port3_overcurrent_in, port2_overcurrent_in, port1_overcurrent_in};
      s_d.oc_sync  = s_q.oc_meta;
      s_d.cmp_meta = analog_oc_cmp;
      s_d.cmp_sync = s_q.cmp_meta;
      s_d.ack_meta = host_dma_ack_pin;
      s_d.ack_sync = s_q.ack_meta;

      // overcurrent detection: active-low digital pins or analog comparators
      // the select acts one edge after the mode write
      oc_now = s_q.mode[BIT_OC_SELECT] ? s_q.cmp_sync : ~s_q.oc_sync;
      // registered level feeds the ports and the edge detector
      s_d.oc_flag = oc_now;

      // overcurrent rising edges and host_event levels become sticky status;
      // a held overcurrent sets once, a held host_event every cycle
      events = '0;
      events[NUM_PORTS-1:0] = oc_now & ~s_q.oc_flag;
      events[BIT_EV_HOST]   = host_event;

      // apb decode; the master holds address, direction and data
      // from setup to completion, so both phases may decode them
      setup       = psel & ~penable;
      access_done = psel & penable & s_q.ready;
      hit_mode    = (paddr == ADDR_MODE);
      hit_status  = (paddr == ADDR_STATUS);
      hit_enable  = (paddr == ADDR_ENABLE);
      w1c         = '0;

      if (setup) begin
         // answer is prepared at the setup edge: zero wait states
         s_d.ready  = 1'b1;
         // unmapped address: error with zero data
         s_d.slverr = ~(hit_mode | hit_status | hit_enable);
         s_d.rdata  = '0;
         // read data is latched here and stands in the access cycle
         if (!pwrite) begin
            if (hit_mode) begin
               s_d.rdata = s_q.mode;
            end else if (hit_status) begin
               s_d.rdata[NUM_EV-1:0] = s_q.status;
            end else if (hit_enable) begin
               s_d.rdata[NUM_EV-1:0] = s_q.enable;
            end
         end
      end else if (access_done) begin
         // completion edge: response flops return to idle
         s_d.ready  = 1'b0;
         s_d.slverr = 1'b0;
         s_d.rdata  = '0;
         // writes land at this edge only; unmapped ones are dropped
         if (pwrite) begin
            if (hit_mode) begin
               // reserved bits are not stored and read as zero
               s_d.mode = pwdata & MODE_WMASK;
            end else if (hit_status) begin
               // a one written clears that status bit
               w1c = pwdata[NUM_EV-1:0];
            end else if (hit_enable) begin
               // enable bits gate each status bit onward
               s_d.enable = pwdata[NUM_EV-1:0];
            end
         end
      end

      // a new event wins over a clear in the same cycle
      s_d.status = (s_q.status & ~w1c) | events;

      // level interrupt of the register bank, from the next state so
      // it moves on the same edge as a status or enable write
      s_d.irq = |(s_d.status & s_d.enable);
   end

   // ****************************************************************
   // host interrupt source: enabled events or shared peripheral line
   // ****************************************************************
   // the shared peripheral line bypasses status and enable; the
   // master gate and the pin polarity are applied in the shaper
   assign irq_request = (|(s_q.status & s_q.enable))
                      | (s_q.mode[BIT_SHARED_IRQ] & periph_interrupt);

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '{mode:     MODE_RESET,
                  status:   EV_RESET,
                  enable:   EV_RESET,
                  rdata:    '0,
                  ready:    1'b0,
                  slverr:   1'b0,
                  irq:      1'b0,
                  // overcurrent pins idle high, no false edge
                  oc_meta:  '1,
                  oc_sync:  '1,
                  cmp_meta: '0,
                  cmp_sync: '0,
                  ack_meta: 1'b0,
                  ack_sync: 1'b0,
                  oc_flag:  '0};
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // response flops drive the bus directly
   assign prdata  = s_q.rdata;
   assign pready  = s_q.ready;
   assign pslverr = s_q.slverr;
   assign irq     = s_q.irq;

   // debug reset, a plain mirror, released by writing zero
   assign usb_transceiver_reset = s_q.mode[BIT_XCVR_RST];
   // one flop feeds all three controllers so they never disagree
   assign host_bus_32   = s_q.mode[BIT_BUS_WIDTH];
   assign periph_bus_32 = s_q.mode[BIT_BUS_WIDTH];
   assign otg_bus_32    = s_q.mode[BIT_BUS_WIDTH];

   // overcurrent level per port, active high once detected
   assign port_overcurrent = s_q.oc_flag;

   // ****************************************************************
   // interrupt pin shaping
   // ****************************************************************
   // the shaper owns polarity, level or pulse and the master gate
   irq_shaper u_irq (
      .core_clk           (core_clk),
      .rst                (rst),
      .cfg                (cfg.dst),
      .irq_request        (irq_request),
      .host_interrupt_pin (host_interrupt_pin)
   );

   // ****************************************************************
   // dma handshake routing
   // ****************************************************************
   // acknowledge enters synchronised; the router adds one flop
   dma_router u_dma (
      .core_clk             (core_clk),
      .rst                  (rst),
      .cfg                  (cfg.dst),
      .host_dma_request     (host_dma_request),
      .periph_dma_request   (periph_dma_request),
      .ack_level            (s_q.ack_sync),
      .host_dma_request_pin (host_dma_request_pin),
      .host_dma_ack         (host_dma_ack),
      .periph_dma_ack       (periph_dma_ack)
   );

endmodule

// *** design/hw_mode_pkg.sv ***
package hw_mode_pkg;

   // ****************************************************************
   // bus geometry
   // ****************************************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ****************************************************************
   // register byte addresses
   // ****************************************************************
   localparam logic [ADDR_W-1:0] ADDR_MODE   = 12'h300;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h310;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE = 12'h314;

   // ****************************************************************
   // mode register field positions
   // ****************************************************************
   localparam int BIT_XCVR_RST   = 31;
   localparam int BIT_OC_SELECT  = 15;
   localparam int BIT_PERIPH_DMA = 11;
   localparam int BIT_SHARED_IRQ = 10;
   localparam int BIT_SHARED_DMA = 9;
   localparam int BIT_BUS_WIDTH  = 8;
   localparam int BIT_ACK_POL    = 6;
   localparam int BIT_REQ_POL    = 5;
   localparam int BIT_IRQ_POL    = 2;
   localparam int BIT_IRQ_TRIG   = 1;
   localparam int BIT_IRQ_EN     = 0;

   // ****************************************************************
   // reset values and writable bits
   // ****************************************************************
   localparam logic [DATA_W-1:0] MODE_RESET = 32'h0000_0100;
   localparam logic [DATA_W-1:0] MODE_WMASK = 32'h8000_8f67;

   // ****************************************************************
   // event status layout
   // ****************************************************************
   localparam int NUM_PORTS = 3;
   localparam int NUM_EV    = 4;  // bits 2..0 port overcurrent, bit 3 host event
   localparam int BIT_EV_HOST = 3;
   localparam logic [NUM_EV-1:0] EV_RESET = 4'h0;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_PS = 4000;
   localparam int IRQ_PULSE_NS  = 40;
   localparam int PULSE_W       = 4;
   localparam logic [PULSE_W-1:0] IRQ_PULSE_CYC =
      PULSE_W'((IRQ_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

endpackage

// *** design/irq_shaper.sv ***
`timescale 1ns/10ps
module irq_shaper
   import hw_mode_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst,
   mode_cfg_if.dst   cfg,
   input  wire logic irq_request,
   output logic      host_interrupt_pin
);

   typedef struct packed {
      logic               pin;
      logic               req_prev;
      logic [PULSE_W-1:0] cnt;
   } shaper_state_t;

   shaper_state_t s_q;
   shaper_state_t s_d;
   logic          gated;
   logic          active;

   // ****************************************************************
   // next state: level or fixed pulse, chosen polarity
   // ****************************************************************
   always_comb begin
      s_d = s_q;
      gated = cfg.irq_master_enable & irq_request;
      s_d.req_prev = gated;
      if (gated && !s_q.req_prev) begin
         s_d.cnt = IRQ_PULSE_CYC;
      end else if (s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - PULSE_W'(1);
      end
      if (!cfg.irq_master_enable) begin
         s_d.cnt = '0;
      end
      active = cfg.irq_trigger_type ? (s_d.cnt != '0) : gated;
      s_d.pin = cfg.irq_polarity ? active : ~active;
   end

   // state register, pin idles low-active-polarity inactive (high)
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '{pin: 1'b1, req_prev: 1'b0, cnt: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign host_interrupt_pin = s_q.pin;

endmodule

// *** design/mode_cfg_if.sv ***
`timescale 1ns/10ps
interface mode_cfg_if;
   logic ack_polarity;
   logic request_polarity;
   logic irq_polarity;
   logic irq_trigger_type;
   logic irq_master_enable;
   logic dma_route;

   modport src (output ack_polarity, request_polarity, irq_polarity, irq_trigger_type,
                irq_master_enable, dma_route);
   modport dst (input ack_polarity, request_polarity, irq_polarity, irq_trigger_type,
                irq_master_enable, dma_route);
endinterface

// *** tb/dma_host_model.sv ***
`timescale 1ns/10ps
// *****
// external dma controller answering the request pin
// *****
module dma_host_model (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic req_pin,
   input  wire logic req_high,
   input  wire logic ack_high,
   input  wire logic slow,
   output logic      ack_pin
);
   logic [3:0] wait_q;

   // acknowledge at once or after a wait, at the configured level
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wait_q  <= 4'h0;
         ack_pin <= 1'b1;
      end else if (req_pin != req_high) begin
         wait_q  <= 4'h0;
         ack_pin <= !ack_high;
      end else begin
         wait_q  <= (wait_q == 4'hf) ? wait_q : wait_q + 4'h1;
         ack_pin <= (wait_q >= (slow ? 4'h4 : 4'h0)) ? ack_high : !ack_high;
      end
   end
endmodule

// *** tb/hw_mode_checker.sv ***
`timescale 1ns/10ps
// *****
// port assertions for the mode control block
// *****
module hw_mode_checker
   import hw_mode_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        irq,
   input wire logic        periph_interrupt,
   input wire logic        host_dma_request,
   input wire logic        periph_dma_request,
   input wire logic        usb_transceiver_reset,
   input wire logic        host_bus_32,
   input wire logic        periph_bus_32,
   input wire logic        otg_bus_32,
   input wire logic [2:0]  port_overcurrent,
   input wire logic        port1_overcurrent_in,
   input wire logic        port2_overcurrent_in,
   input wire logic        port3_overcurrent_in,
   input wire logic [2:0]  analog_oc_cmp,
   input wire logic        host_dma_request_pin,
   input wire logic        host_interrupt_pin
);
   logic [31:0] mode_q;
   logic [2:0]  age_q;
   logic        mode_wr;
   logic        act;
   logic        route;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // completed write to the mode register, pin at its active level
   assign mode_wr = psel && penable && pready && pwrite && paddr == ADDR_MODE;
   assign act     = host_interrupt_pin == mode_q[BIT_IRQ_POL];
   assign route   = mode_q[BIT_PERIPH_DMA] && mode_q[BIT_SHARED_DMA];

   // mirror of the mode register and cycles since it last changed
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_q <= 32'h0000_0100;
         age_q  <= 3'h0;
      end else if (mode_wr) begin
         mode_q <= pwdata & MODE_WMASK;
         age_q  <= 3'h0;
      end else if (age_q != 3'h7) begin
         age_q <= age_q + 3'h1;
      end
   end

   // ten active cycles, then inactive
   sequence s_pulse_body;
      act[*8] ##1 act ##1 act ##1 !act;
   endsequence
   sequence s_pulse_start;
      age_q > 3'h1 && mode_q[BIT_IRQ_TRIG] && mode_q[BIT_IRQ_EN] && act && !$past(act);
   endsequence

   property p_xcvr; age_q > 3'h1 |-> usb_transceiver_reset == mode_q[BIT_XCVR_RST]; endproperty
   a_xcvr: assert property (p_xcvr) else $error("transceiver reset wrong");
   property p_oc;
      age_q > 3'h3 |-> port_overcurrent == (mode_q[BIT_OC_SELECT] ? $past(analog_oc_cmp, 3) :
         ~{$past(port3_overcurrent_in, 3), $past(port2_overcurrent_in, 3), $past(port1_overcurrent_in, 3)});
   endproperty
   a_oc: assert property (p_oc) else $error("overcurrent flag wrong");
   property p_route; age_q > 3'h1 && route |-> host_dma_request_pin == ($past(periph_dma_request) ^ !mode_q[5]); endproperty
   a_route: assert property (p_route) else $error("routed request wrong");
   property p_share;
      age_q > 3'h1 && mode_q[10] && mode_q[0] && !mode_q[1] && $past(periph_interrupt) |-> act;
   endproperty
   a_share: assert property (p_share) else $error("shared interrupt missing");
   property p_read; psel && penable && pready && !pwrite && paddr == ADDR_MODE |-> prdata == mode_q; endproperty
   a_read: assert property (p_read) else $error("mode read wrong");
   property p_bus; age_q > 3'h1 |-> {host_bus_32, periph_bus_32, otg_bus_32} == {3{mode_q[8]}}; endproperty
   a_bus: assert property (p_bus) else $error("bus width differs");
   property p_req; age_q > 3'h1 && !route |-> host_dma_request_pin == ($past(host_dma_request) ^ !mode_q[5]); endproperty
   a_req: assert property (p_req) else $error("request level wrong");
   property p_pulse; s_pulse_start |-> s_pulse_body; endproperty
   a_pulse: assert property (p_pulse) else $error("pulse width wrong");
   property p_off; age_q > 3'h1 && !mode_q[BIT_IRQ_EN] |-> !act; endproperty
   a_off: assert property (p_off) else $error("interrupt while disabled");
   // the host pin is built from registered status, so it trails irq by one edge
   property p_level; age_q > 3'h1 && mode_q[0] && !mode_q[1] && !mode_q[10] |-> act == $past(irq); endproperty
   a_level: assert property (p_level) else $error("level interrupt wrong");
endmodule

bind hardware_mode_control hw_mode_checker u_chk (.*);

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
// *****
// self-checking bench for the mode control block
// *****
module tb_top;
   import hw_mode_pkg::*;
   logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic        host_event, periph_interrupt, host_dma_request, periph_dma_request;
   logic        host_dma_ack, periph_dma_ack, usb_transceiver_reset, host_bus_32;
   logic        periph_bus_32, otg_bus_32, host_dma_ack_pin, host_dma_request_pin;
   logic        host_interrupt_pin, port1_overcurrent_in, port2_overcurrent_in;
   logic        port3_overcurrent_in, slow, err, rt;
   logic [2:0]  port_overcurrent, analog_oc_cmp;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, mode_m, st_m, en_m, rd, seed;
   int          bad_count, cmp_count, n;

   hardware_mode_control dut (.*);
   dma_host_model cpu (.core_clk(core_clk), .rst(rst), .req_pin(host_dma_request_pin), .req_high(mode_m[5]),
                       .ack_high(mode_m[6]), .slow(slow), .ack_pin(host_dma_ack_pin));

   // clock and watchdog sized well above the whole sequence
   always #2 core_clk = ~core_clk;
   initial begin
      #80000;
      bad_count++;
      conclude();
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
      check(32'(err), 32'(experr));
   endtask
   task automatic wr_mode(input logic [31:0] d);
      apb(1'b1, ADDR_MODE, d);
      mode_m = d & 32'h8000_8f67;
   endtask
   task automatic set_en(input logic [31:0] d);
      apb(1'b1, ADDR_ENABLE, d);
      en_m = d;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      {core_clk, psel, penable, pwrite, host_event, periph_interrupt, slow} = '0;
      {host_dma_request, periph_dma_request, paddr, pwdata, analog_oc_cmp} = '0;
      {port1_overcurrent_in, port2_overcurrent_in, port3_overcurrent_in, rst} = 4'hf;
      {st_m, en_m, bad_count, cmp_count} = '0;
      mode_m = 32'h100;
      seed = 32'h039999e7;
      cyc(2);
      rst <= 1'b0;
      rchk(ADDR_MODE, 32'h100, 1'b0);
      check(32'({host_bus_32, periph_bus_32, otg_bus_32}), 32'h7);
      rchk(ADDR_STATUS, 32'h0, 1'b0);
      rchk(12'h304, 32'h0, 1'b1);
      apb(1'b1, 12'h308, 32'hffff_ffff);
      rchk(ADDR_MODE, 32'h100, 1'b0);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wr_mode(i == 7 ? 32'hffff_fef8 : seed & 32'hffff_fff9);
         rchk(ADDR_MODE, mode_m, 1'b0);
         check(32'(usb_transceiver_reset), 32'(mode_m[31]));
         check(32'({host_bus_32, periph_bus_32, otg_bus_32}), {29'h0, {3{mode_m[8]}}});
      end
      // dma routing, request and acknowledge levels in every combination
      for (int i = 0; i < 16; i++) begin
         wr_mode(32'h100 | {20'h0, i[1], 1'b0, i[0], 2'h0, i[3], i[2], 5'h0});
         seed = lfsr(seed);
         slow <= seed[3];
         host_dma_request <= seed[0];
         periph_dma_request <= seed[1];
         rt = i[0] & i[1];
         cyc(12);
         check(32'(host_dma_request_pin), 32'((rt ? seed[1] : seed[0]) ^ !i[2]));
         check(32'({host_dma_ack, periph_dma_ack}), 32'({!rt & seed[0], rt & seed[1]}));
      end
      // level interrupt: raise, mask, gate off, clear
      wr_mode(32'h105);
      set_en(32'h8);
      host_event <= 1'b1;
      @(posedge core_clk);
      host_event <= 1'b0;
      st_m = 32'h8;
      cyc(3);
      check(32'({irq, host_interrupt_pin}), 32'h3);
      rchk(ADDR_STATUS, st_m, 1'b0);
      set_en(32'h0);
      cyc(2);
      check(32'({irq, host_interrupt_pin}), 32'h0);
      set_en(32'h8);
      wr_mode(32'h104);
      cyc(2);
      check(32'({irq, host_interrupt_pin}), 32'h2);
      wr_mode(32'h101);
      cyc(2);
      check(32'(host_interrupt_pin), 32'h0);
      apb(1'b1, ADDR_STATUS, 32'h8);
      st_m = 32'h0;
      cyc(2);
      check(32'({irq, host_interrupt_pin}), 32'h1);
      // pulse mode counts active cycles
      wr_mode(32'h107);
      host_event <= 1'b1;
      @(posedge core_clk);
      host_event <= 1'b0;
      n = 0;
      repeat (20) begin
         @(posedge core_clk);
         n += int'(host_interrupt_pin === 1'b1);
      end
      check(32'(n), 32'ha);
      apb(1'b1, ADDR_STATUS, 32'h8);
      // shared interrupt onto the host pin
      wr_mode(32'h505);
      periph_interrupt <= 1'b1;
      cyc(3);
      check(32'(host_interrupt_pin), 32'h1);
      wr_mode(32'h105);
      cyc(2);
      check(32'(host_interrupt_pin), 32'h0);
      periph_interrupt <= 1'b0;
      // overcurrent, digital then analog
      set_en(32'h7);
      port2_overcurrent_in <= 1'b0;
      cyc(5);
      check(32'(port_overcurrent), 32'h2);
      rchk(ADDR_STATUS, 32'h2, 1'b0);
      port2_overcurrent_in <= 1'b1;
      cyc(5);
      wr_mode(32'h8105);
      analog_oc_cmp <= 3'h5;
      cyc(5);
      check(32'(port_overcurrent), 32'h5);
      check(32'(irq), 32'h1);
      rchk(ADDR_STATUS, 32'h7, 1'b0);
      apb(1'b1, ADDR_STATUS, 32'h7);
      rchk(ADDR_STATUS, 32'h0, 1'b0);
      conclude();
   end
endmodule
